// >>> bench/mra_pin_model.sv
/*
 alert pin model: open-drain wire with a pull-up, as the host sees it.
 assumes: enable high means the design pulls the wire to its data value.
*/
`timescale 1ns/1ps
`default_nettype none
module mra_pin_model (
  input wire logic alert_o_in, // design pin data
  input wire logic alert_oe_in, // design pin enable
  output logic pin_out // resolved wire level
);
  assign pin_out = alert_oe_in ? alert_o_in : 1'b1;
endmodule : mra_pin_model
`default_nettype wire

// >>> bench/tb_top.sv
/*
 self-checking bench for mra_regs: results, flags, alert pin modes.
 assumes: design in core/, pin model in bench/.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mra_cfg.svh"
module tb_top;
  import mra_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, rv = 0, cd = 0, cs = 0, ov = 0, trim = 1;
  mra_addr_t addr = 0;
  mra_word_t wdata = 0;
  logic [15:0] cur = 0;
  logic [23:0] pwr = 0, rdata;
  logic [5:0] lraw = 0, lavg = 0;
  logic ao, aoe, pin;
  int err_total = 0, n_checks = 0, cyc_cnt = 0;
  always #50 clk = ~clk;
  mra_regs DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .RD_IN(rd), .WR_IN(wr),
    .WDATA_IN(wdata), .RDATA_OUT(rdata), .RES_VALID_IN(rv), .CUR_IN(cur), .PWR_IN(pwr),
    .LIM_RAW_IN(lraw), .LIM_AVG_IN(lavg), .CONV_DONE_IN(cd), .CONV_START_IN(cs),
    .OVERFLOW_IN(ov), .TRIM_OK_IN(trim), .ALERT_O_OUT(ao), .ALERT_OE_OUT(aoe));
  mra_pin_model pin_model (.alert_o_in(ao), .alert_oe_in(aoe), .pin_out(pin));
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rd_chk(input mra_addr_t a, input logic [23:0] e);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    chk(rdata, e);
    cyc(1);
  endtask : rd_chk
  task automatic wr_reg(input mra_addr_t a, input mra_word_t d);
    addr = a;
    wdata = d;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask : wr_reg
  task automatic t_results;
    chk({23'h0, pin}, 24'h000001);
    rd_chk(`MRA_OFS_DIAG, 24'h000001);
    rd_chk(`MRA_OFS_CURRENT, 24'h000000);
    rd_chk(`MRA_OFS_POWER, 24'h000000);
    cur = 16'h7ffe;
    pwr = 24'hfedcba;
    rv = 1;
    cyc(1);
    rv = 0;
    wr_reg(`MRA_OFS_CURRENT, 16'h1234);
    rd_chk(`MRA_OFS_CURRENT, 24'h007ffe);
    rd_chk(`MRA_OFS_POWER, 24'hfedcba);
    rd_chk(8'h3c, 24'h000000);
  endtask : t_results
  task automatic t_transp;
    lavg = 6'h3f;
    lraw = 6'h21;
    cyc(3);
    chk({23'h0, pin}, 24'h000000);
    rd_chk(`MRA_OFS_DIAG, 24'h000085);
    lraw = 6'h00;
    cyc(3);
    chk({23'h0, pin}, 24'h000001);
    rd_chk(`MRA_OFS_DIAG, 24'h000001);
    lavg = 6'h00;
  endtask : t_transp
  task automatic t_latch;
    wr_reg(`MRA_OFS_DIAG, 16'hbfff);
    rd_chk(`MRA_OFS_DIAG, 24'h00b001);
    lraw = 6'h3f;
    cyc(3);
    rd_chk(`MRA_OFS_DIAG, 24'h00b001);
    chk({23'h0, pin}, 24'h000000);
    lraw = 6'h00;
    lavg = 6'h10;
    cyc(1);
    lavg = 6'h00;
    cyc(3);
    chk({23'h0, pin}, 24'h000001);
    rd_chk(`MRA_OFS_DIAG, 24'h00b041);
    cyc(2);
    chk({23'h0, pin}, 24'h000000);
    rd_chk(`MRA_OFS_DIAG, 24'h00b001);
  endtask : t_latch
  task automatic t_done;
    wr_reg(`MRA_OFS_DIAG, 16'h4000);
    cd = 1;
    cyc(1);
    cd = 0;
    cyc(3);
    chk({23'h0, pin}, 24'h000000);
    rd_chk(`MRA_OFS_DIAG, 24'h004003);
    ov = 1;
    cyc(1);
    ov = 0;
    cyc(2);
    rd_chk(`MRA_OFS_DIAG, 24'h004203);
    cs = 1;
    cyc(1);
    cs = 0;
    cyc(3);
    chk({23'h0, pin}, 24'h000001);
    rd_chk(`MRA_OFS_DIAG, 24'h004001);
    trim = 0;
    cyc(2);
    rd_chk(`MRA_OFS_DIAG, 24'h004000);
  endtask : t_done
  task automatic t_flags;
    trim = 1;
    wr_reg(`MRA_OFS_DIAG, 16'h8000);
    lraw = 6'h20;
    cyc(1);
    lraw = 6'h00;
    cyc(1);
    chk({23'h0, pin}, 24'h000000);
    rd_chk(`MRA_OFS_DIAG, 24'h008081);
    lraw = 6'h08;
    cyc(1);
    lraw = 6'h00;
    rd_chk(`MRA_OFS_DIAG, 24'h008021);
    lraw = 6'h04;
    cyc(1);
    lraw = 6'h00;
    rd_chk(`MRA_OFS_DIAG, 24'h008011);
    lraw = 6'h02;
    cyc(1);
    lraw = 6'h00;
    rd_chk(`MRA_OFS_DIAG, 24'h008009);
    lraw = 6'h01;
    cyc(1);
    lraw = 6'h00;
    rd_chk(`MRA_OFS_DIAG, 24'h008005);
    cd = 1;
    cyc(1);
    cd = 0;
    cyc(2);
    chk({23'h0, pin}, 24'h000001);
    rd_chk(`MRA_OFS_DIAG, 24'h008003);
    rd_chk(`MRA_OFS_DIAG, 24'h008001);
  endtask : t_flags
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    cyc(16);
    rst_n = 1;
    t_results();
    t_transp();
    t_latch();
    t_done();
    t_flags();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// >>> core/mra_cfg.svh
/*
 contents: offsets, field positions, diagnostic reset value of the monitor result/alert registers.
 assumes: included by core/mra_regs.sv and the bench; core/mra_pkg.sv does not include it.
*/
`ifndef MRA_CFG_SVH
`define MRA_CFG_SVH
`define MRA_OFS_CURRENT 8'h07
`define MRA_OFS_POWER 8'h08
`define MRA_OFS_DIAG 8'h0b
`define MRA_DIAG_RESET 16'h0001
`define MRA_BIT_HOLD 15
`define MRA_BIT_RDY_ROUTE 14
`define MRA_BIT_AVG_CMP 13
`define MRA_BIT_POLARITY 12
`define MRA_BIT_OVERFLOW 9
`define MRA_BIT_TEMP_OVER 7
`define MRA_BIT_SHUNT_OVER 6
`define MRA_BIT_SHUNT_UNDER 5
`define MRA_BIT_BUS_OVER 4
`define MRA_BIT_BUS_UNDER 3
`define MRA_BIT_PWR_OVER 2
`define MRA_BIT_CONV_DONE 1
`define MRA_BIT_TRIM_OK 0
`endif

// >>> core/mra_pkg.sv
/*
 contents: types for the monitor result/alert register bank.
 assumes: nothing beyond the cfg header.
*/
package mra_pkg;
  typedef logic [7:0] mra_addr_t;
  typedef logic [15:0] mra_word_t;
  typedef logic [5:0] mra_lim_t;
endpackage : mra_pkg

// >>> core/mra_regs.sv
/*
 contents: current/power result registers, diagnostic flags and alert control,
 open-drain alert pin drive.
 assumes: serial front end gives one-cycle rd/wr strobes with an address; the
 converter gives per-cycle limit conditions (raw and averaged), conversion done,
 conversion start, overflow and trim status, all synchronous to CLK_IN.
*/
`timescale 1ns/1ps
`include "mra_cfg.svh"
`default_nettype none
module mra_regs
  import mra_pkg::*;
#(
  parameter int CUR_W = 16,
  parameter int PWR_W = 24
) (
  input wire logic CLK_IN, // 10 MHz system clock
  input wire logic RST_N_IN, // sync reset, active low
  input wire logic [7:0] ADDR_IN, // register pointer
  input wire logic RD_IN, // read strobe, one cycle
  input wire logic WR_IN, // write strobe, one cycle
  input wire logic [15:0] WDATA_IN, // write data
  output logic [23:0] RDATA_OUT, // read data, valid cycle after RD_IN
  input wire logic RES_VALID_IN, // new results this cycle
  input wire logic [CUR_W-1:0] CUR_IN, // calculated current
  input wire logic [PWR_W-1:0] PWR_IN, // calculated power
  input wire logic [5:0] LIM_RAW_IN, // raw compare conditions, bits 7..2 order
  input wire logic [5:0] LIM_AVG_IN, // averaged compare conditions, bits 7..2 order
  input wire logic CONV_DONE_IN, // conversion complete pulse
  input wire logic CONV_START_IN, // triggered conversion start pulse
  input wire logic OVERFLOW_IN, // arithmetic overflow pulse
  input wire logic TRIM_OK_IN, // trim checksum good level
  output logic ALERT_O_OUT, // alert pin output value (always 0)
  output logic ALERT_OE_OUT // alert pin pull-down enable
);
  logic [CUR_W-1:0] cur_reg, cur_next;
  logic [PWR_W-1:0] pwr_reg, pwr_next;
  logic [3:0] ctl_reg, ctl_next; // hold, route, avg, polarity
  mra_lim_t lim_reg, lim_next;
  logic done_reg, done_next;
  logic ovf_reg, ovf_next;
  logic trim_reg, trim_next;
  logic [23:0] rdata_reg, rdata_next;
  logic oe_reg, oe_next;
  logic alert_o_reg, alert_o_next;
  mra_word_t diag;
  mra_lim_t cond, lim_calc;
  logic diag_rd, diag_wr, hold, active;

  assign hold = ctl_reg[3];
  assign diag_rd = RD_IN && (ADDR_IN == `MRA_OFS_DIAG);
  assign diag_wr = WR_IN && (ADDR_IN == `MRA_OFS_DIAG);
  // limit conditions already include the direct temperature compare
  assign cond = ctl_reg[1] ? LIM_AVG_IN : LIM_RAW_IN;
  assign active = (|lim_reg) || (done_reg && ctl_reg[2]);

  // diagnostic word assembled from the field positions
  always_comb begin
    diag = 16'h0000;
    diag[`MRA_BIT_HOLD] = ctl_reg[3];
    diag[`MRA_BIT_RDY_ROUTE] = ctl_reg[2];
    diag[`MRA_BIT_AVG_CMP] = ctl_reg[1];
    diag[`MRA_BIT_POLARITY] = ctl_reg[0];
    diag[`MRA_BIT_OVERFLOW] = ovf_reg;
    diag[`MRA_BIT_TEMP_OVER] = lim_reg[5];
    diag[`MRA_BIT_SHUNT_OVER] = lim_reg[4];
    diag[`MRA_BIT_SHUNT_UNDER] = lim_reg[3];
    diag[`MRA_BIT_BUS_OVER] = lim_reg[2];
    diag[`MRA_BIT_BUS_UNDER] = lim_reg[1];
    diag[`MRA_BIT_PWR_OVER] = lim_reg[0];
    diag[`MRA_BIT_CONV_DONE] = done_reg;
    diag[`MRA_BIT_TRIM_OK] = trim_reg;
  end

  // per-flag next value; set wins over the read clear
  for (genvar i = 0; i < 6; i++) begin : g_flag
    assign lim_calc[i] = hold ? (cond[i] || (lim_reg[i] && !diag_rd)) : cond[i];
  end

  always_comb begin
    cur_next = RES_VALID_IN ? CUR_IN : cur_reg;
    pwr_next = RES_VALID_IN ? PWR_IN : pwr_reg;
    ctl_next = diag_wr ? WDATA_IN[15:12] : ctl_reg;
    lim_next = lim_calc;
    if (hold) begin
      done_next = CONV_DONE_IN || (done_reg && !diag_rd && !CONV_START_IN);
    end else begin
      done_next = CONV_DONE_IN || (done_reg && !CONV_START_IN);
    end
    ovf_next = OVERFLOW_IN || (ovf_reg && !CONV_START_IN);
    trim_next = TRIM_OK_IN;
    unique case (ADDR_IN)
      `MRA_OFS_CURRENT: rdata_next = 24'(cur_reg);
      `MRA_OFS_POWER: rdata_next = 24'(pwr_reg);
      `MRA_OFS_DIAG: rdata_next = {8'h00, diag};
      default: rdata_next = 24'h000000;
    endcase
    if (!RD_IN) begin
      rdata_next = rdata_reg;
    end
    // open drain: pull low when active xor inverted polarity
    oe_next = active ^ ctl_reg[0];
    alert_o_next = 1'b0;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cur_reg <= '0;
      pwr_reg <= '0;
      ctl_reg <= 4'h0;
      lim_reg <= 6'h00;
      done_reg <= 1'b0;
      ovf_reg <= 1'b0;
      trim_reg <= 1'b1;
      rdata_reg <= 24'h000000;
      oe_reg <= 1'b0;
      alert_o_reg <= 1'b0;
    end else begin
      cur_reg <= cur_next;
      pwr_reg <= pwr_next;
      ctl_reg <= ctl_next;
      lim_reg <= lim_next;
      done_reg <= done_next;
      ovf_reg <= ovf_next;
      trim_reg <= trim_next;
      rdata_reg <= rdata_next;
      oe_reg <= oe_next;
      alert_o_reg <= alert_o_next;
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign ALERT_O_OUT = alert_o_reg;
  assign ALERT_OE_OUT = oe_reg;

  // reset state
  reset_value_a: assert property (
    @(posedge CLK_IN)
    $rose(RST_N_IN) |-> diag == `MRA_DIAG_RESET)
    else $error("diag reset value wrong");
  reset_outputs_a: assert property (
    @(posedge CLK_IN)
    $rose(RST_N_IN) |-> RDATA_OUT == 24'h000000 && !ALERT_OE_OUT && !ALERT_O_OUT)
    else $error("outputs not idle after reset");
  reset_results_a: assert property (
    @(posedge CLK_IN)
    $rose(RST_N_IN) |-> cur_reg == '0 && pwr_reg == '0)
    else $error("results not zero after reset");

  // result registers, read port and control bit writes
  current_load_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    RES_VALID_IN |=> cur_reg == $past(CUR_IN) && pwr_reg == $past(PWR_IN))
    else $error("results not loaded");
  power_load_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    RES_VALID_IN |=> pwr_reg == $past(PWR_IN))
    else $error("power not loaded");
  result_keep_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !RES_VALID_IN |=> $stable(cur_reg) && $stable(pwr_reg))
    else $error("results changed without load");
  read_current_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN == `MRA_OFS_CURRENT) |=> RDATA_OUT == 24'($past(cur_reg)))
    else $error("current read wrong");
  read_power_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN == `MRA_OFS_POWER) |=> RDATA_OUT == 24'($past(pwr_reg)))
    else $error("power read wrong");
  read_diag_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN == `MRA_OFS_DIAG) |=> RDATA_OUT == {8'h00, $past(diag)})
    else $error("diag read wrong");
  reserved_zero_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    RD_IN && ADDR_IN == `MRA_OFS_DIAG |=> RDATA_OUT[11:10] == 2'b00 && !RDATA_OUT[8])
    else $error("reserved bits nonzero");
  unmapped_zero_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN != `MRA_OFS_CURRENT && ADDR_IN != `MRA_OFS_POWER &&
    ADDR_IN != `MRA_OFS_DIAG) |=> RDATA_OUT == 24'h000000)
    else $error("unmapped read nonzero");
  rdata_keep_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !RD_IN |=> $stable(RDATA_OUT))
    else $error("read data changed without read");
  ctl_write_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    diag_wr |=> ctl_reg == $past(WDATA_IN[15:12]))
    else $error("control bits not written");
  ctl_keep_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !diag_wr |=> $stable(ctl_reg))
    else $error("control bits changed without write");

  // event flags
  latch_hold_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (hold && lim_reg[5] && !diag_rd && !diag_wr) |=> lim_reg[5])
    else $error("latched flag dropped");
  read_clear_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (hold && diag_rd && !diag_wr && cond == 6'h00) |=> lim_reg == 6'h00)
    else $error("read did not clear flags");
  transparent_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!hold && !diag_wr) |=> lim_reg == $past(cond))
    else $error("transparent flags wrong");
  temp_flag_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    cond[5] |=> diag[`MRA_BIT_TEMP_OVER])
    else $error("temperature flag not set");
  shunt_over_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    cond[4] |=> diag[`MRA_BIT_SHUNT_OVER])
    else $error("shunt over flag not set");
  shunt_under_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    cond[3] |=> diag[`MRA_BIT_SHUNT_UNDER])
    else $error("shunt under flag not set");
  bus_over_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    cond[2] |=> diag[`MRA_BIT_BUS_OVER])
    else $error("bus over flag not set");
  bus_under_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    cond[1] |=> diag[`MRA_BIT_BUS_UNDER])
    else $error("bus under flag not set");
  power_flag_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    cond[0] |=> diag[`MRA_BIT_PWR_OVER])
    else $error("power flag not set");
  raw_select_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!ctl_reg[1] && !hold) |=> lim_reg == $past(LIM_RAW_IN))
    else $error("raw compare not used");
  avg_select_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (ctl_reg[1] && !hold) |=> lim_reg == $past(LIM_AVG_IN))
    else $error("averaged compare not used");
  done_set_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    CONV_DONE_IN |=> done_reg)
    else $error("done flag not set");
  done_read_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (hold && diag_rd && !CONV_DONE_IN) |=> !done_reg)
    else $error("latched done not cleared by read");
  done_start_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (CONV_START_IN && !CONV_DONE_IN) |=> !done_reg)
    else $error("done not cleared by start");
  done_keep_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (done_reg && !CONV_START_IN && !(hold && diag_rd)) |=> done_reg)
    else $error("done flag dropped");
  overflow_set_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    OVERFLOW_IN |=> ovf_reg)
    else $error("overflow not set");
  overflow_clear_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (CONV_START_IN && !OVERFLOW_IN) |=> !ovf_reg)
    else $error("overflow kept");
  overflow_keep_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (ovf_reg && !CONV_START_IN) |=> ovf_reg)
    else $error("overflow dropped");
  trim_follow_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> trim_reg == $past(TRIM_OK_IN))
    else $error("trim status not followed");

  // alert pin
  alert_drive_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> ALERT_OE_OUT == ($past(active) ^ $past(ctl_reg[0])))
    else $error("alert drive wrong");
  latch_alert_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (hold && lim_reg != 6'h00 && !ctl_reg[0]) |=> ALERT_OE_OUT)
    else $error("latched alert not driven");
  route_on_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (done_reg && ctl_reg[2] && !ctl_reg[0]) |=> ALERT_OE_OUT)
    else $error("routed done not on alert");
  route_off_a: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (lim_reg == 6'h00 && !ctl_reg[2] && !ctl_reg[0] && !diag_wr) |=> !ALERT_OE_OUT)
    else $error("done drove alert unrouted");
endmodule : mra_regs
`default_nettype wire
